// file: fault_ctl_regs.vh
// register offsets, fields, reset values and timing counts for the fault/inhibit/trigger block
`ifndef FAULT_CTL_REGS_VH
`define FAULT_CTL_REGS_VH
`define CLK_HZ          40000000
`define RELAY_PULSE_MS  1000
`define BLINK_MS        250
`define DEBOUNCE_US     1000
`define OFF_CTRL        8'h00
`define OFF_STATUS      8'h04
`define OFF_ARM         8'h08
`define OFF_SETPOINT    8'h0C
`define OFF_HEATER      8'h10
`define OFF_IRQ_STAT    8'h14
`define OFF_IRQ_MASK    8'h18
`define CTRL_HW_FAULT   0
`define CTRL_OP_FAULT   1
`define CTRL_CLR_HW     2
`define CTRL_CLR_INH    3
`define IRQ_HW          0
`define IRQ_OP          1
`define IRQ_INH         2
`define IRQ_ARM_RAMP_COMMAND        3
`define IRQ_HEAT_REJ    4
`define HEATER_MIN_MA   8'h0A
`define HEATER_MAX_MA   8'h7D
`define HEATER_RST_MA   8'h0A
`define SETP_RST        20'h00000
`endif

// file: fault_inhibit_trigger_control.v
// fault relay, remote shutdown and ramp trigger control with axi4-lite registers
//
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
`include "fault_ctl_regs.vh"
module fault_inhibit_trigger_control #(
	parameter SP_W        = 20,
	parameter PULSE_TICKS = `CLK_HZ / 1000 * `RELAY_PULSE_MS,
	parameter BLINK_TICKS = `CLK_HZ / 1000 * `BLINK_MS,
	parameter DEB_TICKS   = `CLK_HZ / 1000000 * `DEBOUNCE_US
) (
	// clock and reset
	input  wire            clk,
	input  wire            rst,
	// axi4-lite slave
	input  wire [7:0]      s_axi_awaddr,
	input  wire            s_axi_awvalid,
	output wire            s_axi_awready,
	input  wire [31:0]     s_axi_wdata,
	input  wire [3:0]      s_axi_wstrb,
	input  wire            s_axi_wvalid,
	output wire            s_axi_wready,
	output wire [1:0]      s_axi_bresp,
	output reg             s_axi_bvalid,
	input  wire            s_axi_bready,
	input  wire [7:0]      s_axi_araddr,
	input  wire            s_axi_arvalid,
	output wire            s_axi_arready,
	output reg  [31:0]     s_axi_rdata,
	output wire [1:0]      s_axi_rresp,
	output reg             s_axi_rvalid,
	input  wire            s_axi_rready,
	// digital i/o pins
	input  wire            shutdown_n,
	input  wire            ramp_start_n,
	output reg             fault_relay,
	output reg             fault_led,
	output wire            arm_ramp_command_out_o,
	output wire            arm_ramp_command_out_oe,
	// toward the ramp generator and heater source, plus the irq line
	output reg  [SP_W-1:0] current_setpoint,
	output reg             ramp_start,
	output reg  [7:0]      switch_heater_output,
	output wire            irq
);

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers and debounce

reg [1:0] sd_sync_reg;
reg [1:0] tr_sync_reg;
reg       sd_clean_reg;
reg       tr_clean_reg;
// wide counters so any debounce span fits at this clock
reg [31:0] sd_cnt_reg;
reg [31:0] tr_cnt_reg;
reg        sd_prev_reg;
reg        tr_prev_reg;

always @(posedge clk) begin
	if (rst) begin
		sd_sync_reg  <= 2'h3;
		tr_sync_reg  <= 2'h3;
		sd_clean_reg <= 1'b1;
		tr_clean_reg <= 1'b1;
		sd_cnt_reg   <= 32'h0;
		tr_cnt_reg   <= 32'h0;
		sd_prev_reg  <= 1'b1;
		tr_prev_reg  <= 1'b1;
	end else begin
		sd_sync_reg <= {sd_sync_reg[0], shutdown_n};
		tr_sync_reg <= {tr_sync_reg[0], ramp_start_n};
		sd_prev_reg <= sd_clean_reg;
		tr_prev_reg <= tr_clean_reg;
		// a level must hold a whole debounce time before it counts
		if (sd_sync_reg[1] == sd_clean_reg) begin
			sd_cnt_reg <= 32'h0;
		end else if (sd_cnt_reg >= DEB_TICKS - 1) begin
			sd_clean_reg <= sd_sync_reg[1];
			sd_cnt_reg   <= 32'h0;
		end else begin
			sd_cnt_reg <= sd_cnt_reg + 32'h1;
		end
		if (tr_sync_reg[1] == tr_clean_reg) begin
			tr_cnt_reg <= 32'h0;
		end else if (tr_cnt_reg >= DEB_TICKS - 1) begin
			tr_clean_reg <= tr_sync_reg[1];
			tr_cnt_reg   <= 32'h0;
		end else begin
			tr_cnt_reg <= tr_cnt_reg + 32'h1;
		end
	end
end

// both inputs idle high (pull-up outside); low means active
wire sd_active = ~sd_clean_reg;
wire sd_fall   = sd_prev_reg & ~sd_clean_reg;
wire tr_fall   = tr_prev_reg & ~tr_clean_reg;

// trigger output has no function: never driven
assign arm_ramp_command_out_o  = 1'b0;
assign arm_ramp_command_out_oe = 1'b0;

////////////////////////////////////////////////////////////////////////////////
// axi4-lite slave: one write, one read at a time

reg        aw_got_reg;
reg        w_got_reg;
reg [7:0]  aw_addr_reg;
reg [31:0] w_data_reg;
reg [3:0]  w_strb_reg;

assign s_axi_awready = ~aw_got_reg & ~s_axi_bvalid;
assign s_axi_wready  = ~w_got_reg & ~s_axi_bvalid;
assign s_axi_arready = ~s_axi_rvalid;
assign s_axi_bresp   = 2'h0;
assign s_axi_rresp   = 2'h0;

// write effects act at the edge that sees both halves held
wire       wr_fire = aw_got_reg & w_got_reg;
wire [31:0] wd     = w_data_reg;
wire       wr_ctrl = wr_fire & (aw_addr_reg == `OFF_CTRL) & w_strb_reg[0];
wire       wr_arm  = wr_fire & (aw_addr_reg == `OFF_ARM);
wire       wr_heat = wr_fire & (aw_addr_reg == `OFF_HEATER) & w_strb_reg[0];
wire       wr_istat = wr_fire & (aw_addr_reg == `OFF_IRQ_STAT) & w_strb_reg[0];
wire       wr_imask = wr_fire & (aw_addr_reg == `OFF_IRQ_MASK) & w_strb_reg[0];

always @(posedge clk) begin
	if (rst) begin
		aw_got_reg   <= 1'b0;
		w_got_reg    <= 1'b0;
		aw_addr_reg  <= 8'h00;
		w_data_reg   <= 32'h0;
		w_strb_reg   <= 4'h0;
		s_axi_bvalid <= 1'b0;
	end else begin
		if (s_axi_awvalid & s_axi_awready) begin
			aw_got_reg  <= 1'b1;
			aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
		end
		if (s_axi_wvalid & s_axi_wready) begin
			w_got_reg  <= 1'b1;
			w_data_reg <= s_axi_wdata;
			w_strb_reg <= s_axi_wstrb;
		end
		if (wr_fire) begin
			aw_got_reg   <= 1'b0;
			w_got_reg    <= 1'b0;
			s_axi_bvalid <= 1'b1;
		end else if (s_axi_bvalid & s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// fault relay and indicator

reg        hw_fault_reg;
reg        op_active_reg;
reg [31:0] pulse_cnt_reg;
reg        blink_reg;
reg [31:0] blink_cnt_reg;
reg        inh_fault_reg;

wire       hw_set  = wr_ctrl & wd[`CTRL_HW_FAULT];
wire       hw_clr  = wr_ctrl & wd[`CTRL_CLR_HW];
wire       op_set  = wr_ctrl & wd[`CTRL_OP_FAULT];
wire       inh_clr = wr_ctrl & wd[`CTRL_CLR_INH];

// latched hardware fault; a new fault beats a clear
always @(posedge clk) begin
	if (rst) begin
		hw_fault_reg <= 1'b0;
	end else if (hw_set) begin
		hw_fault_reg <= 1'b1;
	end else if (hw_clr) begin
		hw_fault_reg <= 1'b0;
	end
end

// operational fault: 1 s relay pulse, retriggers
always @(posedge clk) begin
	if (rst) begin
		op_active_reg <= 1'b0;
		pulse_cnt_reg <= 32'h0;
	end else if (op_set) begin
		op_active_reg <= 1'b1;
		pulse_cnt_reg <= 32'h0;
	end else if (op_active_reg) begin
		if (pulse_cnt_reg >= PULSE_TICKS - 1) begin
			op_active_reg <= 1'b0;
		end else begin
			pulse_cnt_reg <= pulse_cnt_reg + 32'h1;
		end
	end
end

// free-running blink; its phase is not tied to the fault event
always @(posedge clk) begin
	if (rst) begin
		blink_reg     <= 1'b0;
		blink_cnt_reg <= 32'h0;
	end else if (blink_cnt_reg >= BLINK_TICKS - 1) begin
		blink_cnt_reg <= 32'h0;
		blink_reg     <= ~blink_reg;
	end else begin
		blink_cnt_reg <= blink_cnt_reg + 32'h1;
	end
end

// shutdown fault, also at power-up; a low input beats the clear
always @(posedge clk) begin
	if (rst) begin
		inh_fault_reg <= 1'b0;
	end else if (sd_active) begin
		inh_fault_reg <= 1'b1;
	end else if (inh_clr) begin
		inh_fault_reg <= 1'b0;
	end
end

always @(posedge clk) begin
	if (rst) begin
		fault_relay <= 1'b0;
		fault_led   <= 1'b0;
	end else begin
		fault_relay <= hw_fault_reg | op_active_reg;
		// steady light outranks blinking
		fault_led   <= hw_fault_reg | ((op_active_reg | inh_fault_reg) & blink_reg);
	end
end

////////////////////////////////////////////////////////////////////////////////
// trigger arming, setpoint and shutdown

reg            armed_reg;
reg [SP_W-1:0] armed_sp_reg;
reg            heat_rej_reg;

// an edge during shutdown is dropped, not queued; the arming survives it
wire           arm_ramp_command_fire = armed_reg & tr_fall & ~sd_active;
wire           heat_ok   = (wd[7:0] >= `HEATER_MIN_MA) && (wd[7:0] <= `HEATER_MAX_MA)
	&& (wd[31:8] == 24'h0);

// arming only via command that brings a setpoint
always @(posedge clk) begin
	if (rst) begin
		armed_reg    <= 1'b0;
		armed_sp_reg <= `SETP_RST;
	end else if (wr_arm) begin
		armed_reg    <= 1'b1;
		armed_sp_reg <= wd[SP_W-1:0];
	end else if (arm_ramp_command_fire) begin
		armed_reg <= 1'b0;
	end
end

// shutdown zeroes setpoint only; discharge is up to the output stage
always @(posedge clk) begin
	if (rst) begin
		current_setpoint <= `SETP_RST;
		ramp_start       <= 1'b0;
	end else begin
		ramp_start <= ~wr_arm & arm_ramp_command_fire;
		if (sd_active) begin
			current_setpoint <= {SP_W{1'b0}};
		end else if (~wr_arm & arm_ramp_command_fire) begin
			current_setpoint <= armed_sp_reg;
		end
	end
end

// out-of-range heater values leave the setting alone and raise a flag
always @(posedge clk) begin
	if (rst) begin
		switch_heater_output <= `HEATER_RST_MA;
		heat_rej_reg         <= 1'b0;
	end else begin
		heat_rej_reg <= wr_heat & ~heat_ok;
		if (wr_heat & heat_ok) begin
			switch_heater_output <= wd[7:0];
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// interrupts: sticky, write one to clear, set wins

// one-cycle events stay visible until software clears them
reg  [4:0] irq_stat_reg;
reg  [4:0] irq_mask_reg;
wire [4:0] irq_ev;

assign irq_ev[`IRQ_HW]       = wr_ctrl & wd[`CTRL_HW_FAULT];
assign irq_ev[`IRQ_OP]       = wr_ctrl & wd[`CTRL_OP_FAULT];
assign irq_ev[`IRQ_INH]      = sd_fall;
assign irq_ev[`IRQ_ARM_RAMP_COMMAND]     = ramp_start;
assign irq_ev[`IRQ_HEAT_REJ] = heat_rej_reg;
assign irq = |(irq_stat_reg & irq_mask_reg);

always @(posedge clk) begin
	if (rst) begin
		irq_stat_reg <= 5'h00;
		irq_mask_reg <= 5'h00;
	end else begin
		irq_stat_reg <= (irq_stat_reg & ~(wr_istat ? wd[4:0] : 5'h00)) | irq_ev;
		if (wr_imask) begin
			irq_mask_reg <= wd[4:0];
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// read path

// read data is caught at the address handshake; later changes need a new read
reg [31:0] rd_mux;

always @* begin
	case ({s_axi_araddr[7:2], 2'b00})
	`OFF_CTRL:     rd_mux = 32'h0;
	`OFF_STATUS:   rd_mux = {26'h0, inh_fault_reg, sd_active, armed_reg,
		op_active_reg, hw_fault_reg, fault_relay};
	`OFF_ARM:      rd_mux = {{(32-SP_W){1'b0}}, armed_sp_reg};
	`OFF_SETPOINT: rd_mux = {{(32-SP_W){1'b0}}, current_setpoint};
	`OFF_HEATER:   rd_mux = {24'h0, switch_heater_output};
	`OFF_IRQ_STAT: rd_mux = {27'h0, irq_stat_reg};
	`OFF_IRQ_MASK: rd_mux = {27'h0, irq_mask_reg};
	default:       rd_mux = 32'h0;
	endcase
end

always @(posedge clk) begin
	if (rst) begin
		s_axi_rvalid <= 1'b0;
		s_axi_rdata  <= 32'h0;
	end else if (s_axi_arvalid & s_axi_arready) begin
		s_axi_rvalid <= 1'b1;
		s_axi_rdata  <= rd_mux;
	end else if (s_axi_rvalid & s_axi_rready) begin
		s_axi_rvalid <= 1'b0;
	end
end

endmodule // fault_inhibit_trigger_control

// file: fault_ctl_monitor.sv
// port-level checker for the fault, shutdown and trigger block
`timescale 1ns/100ps
module fault_ctl_monitor #(
	parameter SP_W      = 20,
	parameter DEB_TICKS = 4
) (
	// clock and reset
	input wire logic            clk,
	input wire logic            rst,
	// pins and outputs
	input wire logic            shutdown_n,
	input wire logic            ramp_start_n,
	input wire logic            fault_relay,
	input wire logic            arm_ramp_command_out_o,
	input wire logic            arm_ramp_command_out_oe,
	input wire logic [SP_W-1:0] current_setpoint,
	input wire logic            ramp_start,
	input wire logic [7:0]      switch_heater_output
);
	int lo_cnt;
	int hi_cnt;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////
	// run lengths of the raw level, saturated so they never wrap
	always @(posedge clk) begin
		lo_cnt <= (rst || shutdown_n) ? 0 : ((lo_cnt < 999) ? lo_cnt + 1 : lo_cnt);
		hi_cnt <= (rst || !shutdown_n) ? 0 : ((hi_cnt < 999) ? hi_cnt + 1 : hi_cnt);
	end
	////////////////////////////////////////
	property p_arm_ramp_command_idle; !arm_ramp_command_out_oe && !arm_ramp_command_out_o; endproperty
	a_arm_ramp_command_idle: assert property (p_arm_ramp_command_idle) else $error("trigger output driven");
	property p_heat; switch_heater_output >= 8'h0A && switch_heater_output <= 8'h7D; endproperty
	a_heat: assert property (p_heat) else $error("heater setting out of range");
	property p_sd_zero; lo_cnt > DEB_TICKS + 4 |-> current_setpoint == '0; endproperty
	a_sd_zero: assert property (p_sd_zero) else $error("setpoint not zero in shutdown");
	property p_sd_noramp; lo_cnt > DEB_TICKS + 4 |-> !ramp_start; endproperty
	a_sd_noramp: assert property (p_sd_noramp) else $error("ramp started in shutdown");
	property p_ramp_pulse; ramp_start |=> !ramp_start; endproperty
	a_ramp_pulse: assert property (p_ramp_pulse) else $error("ramp start too long");
	property p_ramp_cause; ramp_start |-> !$past(ramp_start_n, 3); endproperty
	a_ramp_cause: assert property (p_ramp_cause) else $error("ramp without held trigger");
	// setpoint moves only by a trigger or a shutdown
	property p_sp_hold; hi_cnt > DEB_TICKS + 4 && !ramp_start |-> $stable(current_setpoint);
	endproperty
	a_sp_hold: assert property (p_sp_hold) else $error("setpoint moved without trigger");
	property p_rst_vals; disable iff (1'b0)
		rst |=> switch_heater_output == 8'h0A && !fault_relay && current_setpoint == '0;
	endproperty
	a_rst_vals: assert property (p_rst_vals) else $error("bad value after reset");
endmodule // fault_ctl_monitor

// file: far_side_model.sv
// far side: shutdown switch and trigger contact on pulled-up lines
`timescale 1ns/100ps
module far_side_model (
	// requests from the bench
	input  wire logic sd_req,
	input  wire logic arm_ramp_command_req,
	// contact lines
	output wire logic shutdown_n,
	output wire logic ramp_start_n
);
	// a released contact leaves the line at the pull-up level
	assign shutdown_n   = sd_req ? 1'h0 : 1'h1;
	assign ramp_start_n = arm_ramp_command_req ? 1'h0 : 1'h1;
endmodule // far_side_model

// file: fault_inhibit_trigger_control_bench.sv
// self-checking bench for the fault, shutdown and trigger block
`timescale 1ns/100ps
`include "fault_ctl_regs.vh"
module fault_inhibit_trigger_control_bench;
	logic        clk = 0, rst = 1, s, sd_req = 0, arm_ramp_command_req = 0;
	logic [7:0]  awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, d;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	wire         awready, wready, bvalid, arready, rvalid, irq, shutdown_n, ramp_start_n;
	wire         fault_relay, fault_led, ramp_start;
	wire  [31:0] rdata;
	wire  [19:0] sp;
	wire  [7:0]  heat;
	int          miscompares = 0, num_checks = 0, hr, hl;
	logic [31:0] hv [6] = '{32'h9, 32'h7D, 32'h7E, 32'h17D, 32'h40, 32'hA};
	logic [7:0]  he [6] = '{8'hA, 8'h7D, 8'h7D, 8'h7D, 8'h40, 8'hA};
	fault_inhibit_trigger_control #(.PULSE_TICKS(50), .BLINK_TICKS(8), .DEB_TICKS(4)) dut_u (
		.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .shutdown_n(shutdown_n), .ramp_start_n(ramp_start_n),
		.fault_relay(fault_relay), .fault_led(fault_led), .arm_ramp_command_out_o(), .arm_ramp_command_out_oe(),
		.current_setpoint(sp), .ramp_start(ramp_start), .switch_heater_output(heat), .irq(irq));
	far_side_model far_u (.sd_req(sd_req), .arm_ramp_command_req(arm_ramp_command_req), .shutdown_n(shutdown_n),
		.ramp_start_n(ramp_start_n));
	initial forever #12.5 clk = ~clk;
	////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// handshakes are judged at the negedge, where the edge's values already stand
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic pa, pw, pb;
		{awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'h7};
		pb = 0;
		while (!pb) begin
			@(negedge clk);
			pa = awvalid & awready;
			pw = wvalid & wready;
			pb = bvalid;
			@(posedge clk);
			if (pa) awvalid <= 1'h0;
			if (pw) wvalid <= 1'h0;
		end
		bready <= 1'h0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		logic pa, pr;
		{araddr, arvalid, rready} <= {a, 2'h3};
		pr = 0;
		while (!pr) begin
			@(negedge clk);
			pa = arvalid & arready;
			pr = rvalid;
			v = rdata;
			@(posedge clk);
			if (pa) arvalid <= 1'h0;
		end
		rready <= 1'h0;
		@(posedge clk);
	endtask
	task automatic count(input int n);
		hr = 0;
		hl = 0;
		repeat (n) begin
			@(negedge clk);
			hr += fault_relay;
			hl += fault_led;
		end
		@(posedge clk);
	endtask
	// trigger held 16 cycles, well past the debounce span, then released for 12
	task automatic press;
		s = 0;
		arm_ramp_command_req <= 1'h1;
		repeat (16) begin
			@(negedge clk);
			if (ramp_start === 1'h1) s = 1;
			@(posedge clk);
		end
		arm_ramp_command_req <= 1'h0;
		repeat (12) @(posedge clk);
	endtask
	////////////////////////////////////////
	task automatic t_reset;
		@(negedge clk);
		chk(heat, 8'hA);
		chk({sp, fault_relay, fault_led, ramp_start}, 0);
		@(posedge clk);
		rd(`OFF_STATUS, d);
		chk(d, 0);
		$display("test reset done");
	endtask
	task automatic t_faults;
		wr(`OFF_CTRL, 32'h1);
		count(40);
		chk(hr, 40);
		chk(hl, 40);
		wr(`OFF_CTRL, 32'h4);
		count(4);
		chk(hr, 0);
		fork
			wr(`OFF_CTRL, 32'h2);
			count(120);
		join
		chk(hr, 50);
		chk(hl > 0 && hl < 120, 1);
		$display("test faults done");
	endtask
	task automatic t_arm_ramp_command;
		press;
		chk(s, 0);
		wr(`OFF_ARM, 32'h12345);
		press;
		chk({s, sp}, 21'h112345);
		press;
		chk({s, sp}, 21'h012345);
		wr(`OFF_ARM, 32'hABCDE);
		press;
		chk({s, sp}, 21'h1ABCDE);
		rd(`OFF_SETPOINT, d);
		chk(d, 32'hABCDE);
		rd(`OFF_ARM, d);
		chk(d, 32'hABCDE);
		$display("test trigger done");
	endtask
	task automatic t_heat;
		for (int i = 0; i < 6; i++) begin
			wr(`OFF_HEATER, hv[i]);
			chk(heat, he[i]);
		end
		rd(`OFF_IRQ_STAT, d);
		chk(d[4:0], 5'h1B);
		rd(8'h1C, d);
		chk(d, 32'h0);
		rd(`OFF_HEATER, d);
		chk(d, 32'hA);
		$display("test heater done");
	endtask
	task automatic t_irq;
		wr(`OFF_IRQ_MASK, 32'h1F);
		chk(irq, 1);
		wr(`OFF_IRQ_MASK, 32'h0);
		chk(irq, 0);
		wr(`OFF_IRQ_MASK, 32'h1F);
		wr(`OFF_IRQ_STAT, 32'h1F);
		chk(irq, 0);
		rd(`OFF_IRQ_STAT, d);
		chk(d, 0);
		$display("test irq done");
	endtask
	task automatic t_sd;
		wr(`OFF_ARM, 32'h222);
		sd_req <= 1'h1;
		repeat (12) @(posedge clk);
		chk({sp, fault_relay}, 0);
		press;
		chk({s, fault_relay}, 0);
		// power-up with the partner still holding the line low
		rst <= 1'h1;
		repeat (4) @(posedge clk);
		rst <= 1'h0;
		repeat (12) @(posedge clk);
		// a clear while the line is still low must not stick
		wr(`OFF_CTRL, 32'h8);
		rd(`OFF_STATUS, d);
		chk(d[5], 1);
		sd_req <= 1'h0;
		repeat (12) @(posedge clk);
		rd(`OFF_STATUS, d);
		chk(d[5], 1);
		wr(`OFF_CTRL, 32'h8);
		rd(`OFF_STATUS, d);
		chk(d[5], 0);
		$display("test shutdown done");
	endtask
	task automatic wrap_up;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'h0;
		t_reset;
		t_faults;
		t_arm_ramp_command;
		t_heat;
		t_irq;
		t_sd;
		wrap_up;
	end
	initial begin
		#500000;
		miscompares++;
		wrap_up;
	end
endmodule // fault_inhibit_trigger_control_bench
bind fault_inhibit_trigger_control fault_ctl_monitor #(.SP_W(SP_W), .DEB_TICKS(DEB_TICKS)) mon_u (
	.clk(clk), .rst(rst), .shutdown_n(shutdown_n), .ramp_start_n(ramp_start_n),
	.fault_relay(fault_relay), .arm_ramp_command_out_o(arm_ramp_command_out_o), .arm_ramp_command_out_oe(arm_ramp_command_out_oe),
	.current_setpoint(current_setpoint), .ramp_start(ramp_start),
	.switch_heater_output(switch_heater_output));
